// file: logic/dswc_top.sv
// deep sleep entry, wake logging, pin hold and persistent scratch registers
// assumes one clock, synchronous inputs, software as the only AXI4-Lite master
`timescale 1ns/1ps

module dswc_top #(
  parameter int ADDR_W     = 16,
  parameter int NUM_PINS   = 8,
  parameter int INSTR_CLKS = 1,
  parameter int POR_CYCLES = 16
) (
  input  wire logic                   MCLK_I,
  input  wire logic                   RST_I,
  input  wire logic [ADDR_W-1:0]      S_AXI_AWADDR_I,
  input  wire logic                   S_AXI_AWVALID_I,
  output logic                        S_AXI_AWREADY_O,
  input  wire logic [31:0]            S_AXI_WDATA_I,
  input  wire logic [3:0]             S_AXI_WSTRB_I,
  input  wire logic                   S_AXI_WVALID_I,
  output logic                        S_AXI_WREADY_O,
  output logic [1:0]                  S_AXI_BRESP_O,
  output logic                        S_AXI_BVALID_O,
  input  wire logic                   S_AXI_BREADY_I,
  input  wire logic [ADDR_W-1:0]      S_AXI_ARADDR_I,
  input  wire logic                   S_AXI_ARVALID_I,
  output logic                        S_AXI_ARREADY_O,
  output logic [31:0]                 S_AXI_RDATA_O,
  output logic [1:0]                  S_AXI_RRESP_O,
  output logic                        S_AXI_RVALID_O,
  input  wire logic                   S_AXI_RREADY_I,
  input  wire logic                   SLEEP_CMD_I,
  input  wire dswc_pkg::dswc_wake_t   WAKE_SRC_I,
  input  wire dswc_pkg::dswc_supply_t SUPPLY_I,
  input  wire logic [NUM_PINS-1:0]    PIN_DIRECTION_I,
  input  wire logic [NUM_PINS-1:0]    OUTPUT_LATCH_I,
  output logic [NUM_PINS-1:0]         PIN_OUT_O,
  output logic [NUM_PINS-1:0]         PIN_OE_N_O,
  output logic                        DEEP_SLEEP_O,
  output logic                        SLEEP_O,
  output logic                        POR_ACTIVE_O,
  output logic                        DEEP_SLEEP_EXIT_O,
  output logic                        ULP_UNIT_RUN_O
);
  import dswc_pkg::*;

  // ----------------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------------
  localparam int DEEP_SLEEP_ENABLE_CLKS = `DSWC_DEEP_SLEEP_ENABLE_LIFE_INSTR * INSTR_CLKS;
  localparam int CNT_W     = 16;

  generate
    if (ADDR_W < 14 || ADDR_W > 32) begin : g_bad_addr
      $error("address width must be 14 to 32");
    end
    if (NUM_PINS < 1 || INSTR_CLKS < 1 || POR_CYCLES < 1) begin : g_bad_cnt
      $error("pin count and cycle counts must be positive");
    end
    if (DEEP_SLEEP_ENABLE_CLKS >= (1 << CNT_W) || POR_CYCLES >= (1 << CNT_W)) begin : g_big_cnt
      $error("cycle counts exceed counter width");
    end
  endgenerate

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  dswc_state_t       state;
  dswc_state_t       next_state;
  logic [7:0]        wake_low;
  logic [7:0]        wake_high;
  logic [7:0]        ctrl_low;
  logic [7:0]        ctrl_high;
  logic [7:0]        scratch0;
  logic [7:0]        scratch1;
  logic [CNT_W-1:0]  deep_sleep_enable_cnt;
  logic [CNT_W-1:0]  por_cnt;
  logic [NUM_PINS-1:0] held_dir;
  logic [NUM_PINS-1:0] held_out;

  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] waddr;
  logic [7:0]        wdata;
  logic              wlane;
  logic              wr_do;
  logic              sel_wl;
  logic              sel_wh;
  logic              sel_cl;
  logic              sel_ch;
  logic              sel_s0;
  logic              sel_s1;
  logic              wr_hit;
  logic              rd_hit;
  logic [7:0]        rd_byte;

  logic              enter_deep;
  logic              in_deep;
  logic              ulp_ok;
  logic              cal_ok;
  logic              deep_sleep_brownout_flag_loss;
  logic              scratch_loss;
  logic              wake_req;
  logic [7:0]        wake_low_set;
  logic              wake_high_set;
  logic              por_done;
  logic              deep_sleep_enable_set;

  // ----------------------------------------------------------------------------
  // wake request merge
  // ----------------------------------------------------------------------------
  assign in_deep    = (state == DSWC_DEEP);
  assign enter_deep = (state == DSWC_RUN) && SLEEP_CMD_I && ctrl_high[`DSWC_CH_DEEP_SLEEP_ENABLE];
  assign ulp_ok     = ctrl_high[`DSWC_CH_ULP_EN] && !ctrl_low[`DSWC_CL_ULP_DIS];
  assign cal_ok     = !ctrl_high[`DSWC_CH_CAL_DIS];
  assign deep_sleep_brownout_flag_loss = in_deep && SUPPLY_I.deep_sleep_brownout_flag_en && SUPPLY_I.deep_sleep_brownout_flag_trip;
  assign scratch_loss = (SUPPLY_I.core_bor && !in_deep) || deep_sleep_brownout_flag_loss
                      || SUPPLY_I.vdd_near_zero;

  // only one source is logged even when several fire together; fault ranks first
  always_comb begin
    wake_low_set  = 8'h00;
    wake_high_set = 1'b0;
    wake_req      = 1'b0;
    if (in_deep) begin
      wake_req = 1'b1;
      if (WAKE_SRC_I.fault) begin
        wake_low_set[`DSWC_WL_FAULT] = 1'b1;
      end else if (WAKE_SRC_I.por_event) begin
        wake_low_set[`DSWC_WL_POR] = 1'b1;
      end else if (WAKE_SRC_I.master_clear_pin) begin
        wake_low_set[`DSWC_WL_MASTER_CLEAR_PIN] = 1'b1;
      end else if (WAKE_SRC_I.wdt) begin
        wake_low_set[`DSWC_WL_WDT] = 1'b1;
      end else if (WAKE_SRC_I.cal_alarm && cal_ok) begin
        wake_low_set[`DSWC_WL_CAL] = 1'b1;
      end else if (WAKE_SRC_I.ulp && ulp_ok) begin
        wake_low_set[`DSWC_WL_ULP] = 1'b1;
      end else if (WAKE_SRC_I.pin_int) begin
        wake_high_set = 1'b1;
      end else if (deep_sleep_brownout_flag_loss) begin
        wake_req = 1'b1;
      end else begin
        wake_req = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------------------
  assign por_done = (state == DSWC_POR) && (por_cnt == CNT_W'(POR_CYCLES - 1));

  always_comb begin
    next_state = state;
    case (state)
      DSWC_RUN: begin
        if (enter_deep) begin
          next_state = DSWC_DEEP;
        end
      end
      DSWC_DEEP: begin
        if (wake_req) begin
          next_state = DSWC_POR;
        end
      end
      DSWC_POR: begin
        if (por_done) begin
          next_state = DSWC_RUN;
        end
      end
      default: begin
        next_state = DSWC_RUN;
      end
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state <= DSWC_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I || state != DSWC_POR) begin
      por_cnt <= '0;
    end else begin
      por_cnt <= por_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      SLEEP_O           <= 1'b0;
      DEEP_SLEEP_EXIT_O <= 1'b0;
    end else begin
      SLEEP_O           <= (state == DSWC_RUN) && SLEEP_CMD_I
                           && !ctrl_high[`DSWC_CH_DEEP_SLEEP_ENABLE];
      DEEP_SLEEP_EXIT_O <= por_done;
    end
  end

  assign DEEP_SLEEP_O   = in_deep;
  assign POR_ACTIVE_O   = (state == DSWC_POR);
  assign ULP_UNIT_RUN_O = in_deep && ctrl_high[`DSWC_CH_ULP_EN];

  // ----------------------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------------------
  assign S_AXI_AWREADY_O = !aw_held && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O  = !w_held && !S_AXI_BVALID_O;
  assign wr_do           = aw_held && w_held;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      aw_held <= 1'b0;
      waddr   <= '0;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_held <= 1'b1;
      waddr   <= S_AXI_AWADDR_I;
    end else if (wr_do) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      w_held <= 1'b0;
      wdata  <= 8'h00;
      wlane  <= 1'b0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_held <= 1'b1;
      wdata  <= S_AXI_WDATA_I[7:0];
      wlane  <= S_AXI_WSTRB_I[0];
    end else if (wr_do) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    sel_wl = 1'b0;
    sel_wh = 1'b0;
    sel_cl = 1'b0;
    sel_ch = 1'b0;
    sel_s0 = 1'b0;
    sel_s1 = 1'b0;
    if (waddr == byte_addr(`DSWC_IDX_WAKE_LOW)) begin
      sel_wl = 1'b1;
    end else if (waddr == byte_addr(`DSWC_IDX_WAKE_HIGH)) begin
      sel_wh = 1'b1;
    end else if (waddr == byte_addr(`DSWC_IDX_CTRL_LOW)) begin
      sel_cl = 1'b1;
    end else if (waddr == byte_addr(`DSWC_IDX_CTRL_HIGH)) begin
      sel_ch = 1'b1;
    end else if (waddr == byte_addr(`DSWC_IDX_SCRATCH0)) begin
      sel_s0 = 1'b1;
    end else if (waddr == byte_addr(`DSWC_IDX_SCRATCH1)) begin
      sel_s1 = 1'b1;
    end
  end

  assign wr_hit = sel_wl || sel_wh || sel_cl || sel_ch || sel_s0 || sel_s1;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= `DSWC_RESP_OKAY;
    end else if (wr_do) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O  <= wr_hit ? `DSWC_RESP_OKAY : `DSWC_RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // wake status registers
  // ----------------------------------------------------------------------------
  // hardware sets are applied after the software write so a set never gets lost to a write
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      wake_low <= `DSWC_RST_WAKE_LOW;
    end else if (enter_deep) begin
      wake_low <= 8'h00;
    end else begin
      if (wr_do && wlane && sel_wl) begin
        wake_low <= (wake_low & ~`DSWC_MASK_WAKE_LOW) | (wdata & `DSWC_MASK_WAKE_LOW);
      end
      if (state == DSWC_DEEP && state != next_state) begin
        wake_low <= wake_low | wake_low_set;
      end else if (WAKE_SRC_I.por_event && state != DSWC_DEEP) begin
        wake_low[`DSWC_WL_POR] <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      wake_high <= `DSWC_RST_WAKE_HIGH;
    end else if (enter_deep) begin
      wake_high <= 8'h00;
    end else begin
      if (wr_do && wlane && sel_wh) begin
        wake_high <= (wake_high & ~`DSWC_MASK_WAKE_HIGH) | (wdata & `DSWC_MASK_WAKE_HIGH);
      end
      if (wake_high_set) begin
        wake_high[`DSWC_WH_PIN_INT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------------
  // reset wake clears the high control byte; release and brown-out survive it
  always_ff @(posedge MCLK_I) begin
    if (RST_I || por_done) begin
      ctrl_high <= `DSWC_RST_CTRL_HIGH;
    end else begin
      if (wr_do && wlane && sel_ch) begin
        ctrl_high <= (ctrl_high & ~`DSWC_MASK_CTRL_HIGH) | (wdata & `DSWC_MASK_CTRL_HIGH);
      end
      // a fresh set in the last cycle restarts the lifetime instead of being lost
      if ((deep_sleep_enable_cnt == CNT_W'(1) && !deep_sleep_enable_set) || enter_deep) begin
        ctrl_high[`DSWC_CH_DEEP_SLEEP_ENABLE] <= 1'b0;
      end
    end
  end

  // enable lifetime counted from the write that sets it
  assign deep_sleep_enable_set = wr_do && wlane && sel_ch && wdata[`DSWC_CH_DEEP_SLEEP_ENABLE];

  always_ff @(posedge MCLK_I) begin
    if (RST_I || por_done || enter_deep) begin
      deep_sleep_enable_cnt <= '0;
    end else if (deep_sleep_enable_set) begin
      deep_sleep_enable_cnt <= CNT_W'(DEEP_SLEEP_ENABLE_CLKS);
    end else if (deep_sleep_enable_cnt != '0) begin
      deep_sleep_enable_cnt <= deep_sleep_enable_cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ctrl_low <= `DSWC_RST_CTRL_LOW;
    end else begin
      if (wr_do && wlane && sel_cl) begin
        ctrl_low <= (ctrl_low & ~`DSWC_MASK_CTRL_LOW) | (wdata & `DSWC_MASK_CTRL_LOW);
      end
      if (enter_deep) begin
        ctrl_low[`DSWC_CL_RELEASE]  <= 1'b1;
        ctrl_low[`DSWC_CL_BROWNOUT] <= 1'b0;
      end else if (in_deep) begin
        if (SUPPLY_I.deep_sleep_brownout_flag_arm && !SUPPLY_I.deep_sleep_brownout_flag_trip) begin
          ctrl_low[`DSWC_CL_BROWNOUT] <= 1'b1;
        end
        // reset pin, when it is the logged wake source, and supply collapse release the pins straight away
        if (deep_sleep_brownout_flag_loss || (WAKE_SRC_I.master_clear_pin && wake_low_set[`DSWC_WL_MASTER_CLEAR_PIN])) begin
          ctrl_low[`DSWC_CL_RELEASE] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // persistent scratch
  // ----------------------------------------------------------------------------
  // not touched by the system reset: contents must outlive the wake reset
  always_ff @(posedge MCLK_I) begin
    if (scratch_loss) begin
      scratch0 <= 8'h00;
      scratch1 <= 8'h00;
    end else if (wr_do && wlane && !in_deep) begin
      if (sel_s0) begin
        scratch0 <= wdata;
      end
      if (sel_s1) begin
        scratch1 <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // pin hold
  // ----------------------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      held_dir <= '1;
      held_out <= '0;
    end else if (enter_deep) begin
      held_dir <= PIN_DIRECTION_I;
      held_out <= OUTPUT_LATCH_I;
    end
  end

  // direction bit 1 means input, so the enable stays high and the pin floats
  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
          PIN_OE_N_O[i] <= 1'b1;
          PIN_OUT_O[i]  <= 1'b0;
        end else if (ctrl_low[`DSWC_CL_RELEASE]) begin
          PIN_OE_N_O[i] <= held_dir[i];
          PIN_OUT_O[i]  <= held_out[i];
        end else begin
          PIN_OE_N_O[i] <= PIN_DIRECTION_I[i];
          PIN_OUT_O[i]  <= OUTPUT_LATCH_I[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------------------
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (S_AXI_ARADDR_I == byte_addr(`DSWC_IDX_WAKE_LOW)) begin
      rd_byte = wake_low;
    end else if (S_AXI_ARADDR_I == byte_addr(`DSWC_IDX_WAKE_HIGH)) begin
      rd_byte = wake_high;
    end else if (S_AXI_ARADDR_I == byte_addr(`DSWC_IDX_CTRL_LOW)) begin
      rd_byte = ctrl_low;
    end else if (S_AXI_ARADDR_I == byte_addr(`DSWC_IDX_CTRL_HIGH)) begin
      rd_byte = ctrl_high;
    end else if (S_AXI_ARADDR_I == byte_addr(`DSWC_IDX_SCRATCH0)) begin
      rd_byte = scratch0;
    end else if (S_AXI_ARADDR_I == byte_addr(`DSWC_IDX_SCRATCH1)) begin
      rd_byte = scratch1;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= 32'h0000_0000;
      S_AXI_RRESP_O  <= `DSWC_RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O  <= {24'h00_0000, rd_byte};
      S_AXI_RRESP_O  <= rd_hit ? `DSWC_RESP_OKAY : `DSWC_RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

endmodule

// file: pkg/dswc_cfg.svh
// constants of the deep sleep wake controller: register indexes, field positions,
// reset values and timing counts; included by the package and the testbench
`ifndef DSWC_CFG_SVH
`define DSWC_CFG_SVH

// ----------------------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------------------
`define DSWC_IDX_WAKE_LOW      12'hf4a
`define DSWC_IDX_WAKE_HIGH     12'hf4b
`define DSWC_IDX_CTRL_LOW      12'hf4c
`define DSWC_IDX_CTRL_HIGH     12'hf4d
`define DSWC_IDX_SCRATCH0      12'hf4e
`define DSWC_IDX_SCRATCH1      12'hf4f

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define DSWC_WL_FAULT          7
`define DSWC_WL_ULP            5
`define DSWC_WL_WDT            4
`define DSWC_WL_CAL            3
`define DSWC_WL_MASTER_CLEAR_PIN           2
`define DSWC_WL_POR            0
`define DSWC_WH_PIN_INT        0
`define DSWC_CH_DEEP_SLEEP_ENABLE           7
`define DSWC_CH_ULP_EN         1
`define DSWC_CH_CAL_DIS        0
`define DSWC_CL_ULP_DIS        2
`define DSWC_CL_BROWNOUT       1
`define DSWC_CL_RELEASE        0

// ----------------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------------
`define DSWC_RST_WAKE_LOW      8'h01
`define DSWC_RST_WAKE_HIGH     8'h00
`define DSWC_RST_CTRL_LOW      8'h00
`define DSWC_RST_CTRL_HIGH     8'h00
`define DSWC_MASK_WAKE_LOW     8'hbd
`define DSWC_MASK_WAKE_HIGH    8'h01
`define DSWC_MASK_CTRL_LOW     8'h07
`define DSWC_MASK_CTRL_HIGH    8'h87

// ----------------------------------------------------------------------------
// timing and bus answers
// ----------------------------------------------------------------------------
`define DSWC_DEEP_SLEEP_ENABLE_LIFE_INSTR   2
`define DSWC_RESP_OKAY         2'b00
`define DSWC_RESP_SLVERR       2'b10

`endif

// file: pkg/dswc_pkg.sv
// types of the deep sleep wake controller
// assumes dswc_cfg.svh is on the include path
package dswc_pkg;
  `include "dswc_cfg.svh"

  typedef enum logic [2:0] {
    DSWC_RUN  = 3'b001,
    DSWC_DEEP = 3'b010,
    DSWC_POR  = 3'b100
  } dswc_state_t;

  typedef struct packed {
    logic fault;
    logic por_event;
    logic master_clear_pin;
    logic wdt;
    logic cal_alarm;
    logic ulp;
    logic pin_int;
  } dswc_wake_t;

  typedef struct packed {
    logic deep_sleep_brownout_flag_en;
    logic deep_sleep_brownout_flag_arm;
    logic deep_sleep_brownout_flag_trip;
    logic core_bor;
    logic vdd_near_zero;
  } dswc_supply_t;
endpackage

// file: bench/dswc_props.sv
// checker: sleep entry, wake and wake reset timing at the top ports
// assumes it is bound to dswc_top and given the same POR_CYCLES
`timescale 1ns/1ps
module dswc_props #(
  parameter int POR_CYCLES = 16
) (
  input wire logic                   MCLK_I,
  input wire logic                   RST_I,
  input wire logic                   SLEEP_CMD_I,
  input wire dswc_pkg::dswc_wake_t   WAKE_SRC_I,
  input wire dswc_pkg::dswc_supply_t SUPPLY_I,
  input wire logic                   DEEP_SLEEP_O,
  input wire logic                   SLEEP_O,
  input wire logic                   POR_ACTIVE_O,
  input wire logic                   DEEP_SLEEP_EXIT_O,
  input wire logic                   ULP_UNIT_RUN_O
);
  import dswc_pkg::*;
  logic [7:0] por_len;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // ------------------------------------------------------------------
  // wake reset length, so an over-long reset shows up
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (RST_I || !POR_ACTIVE_O) por_len <= 8'h00;
    else por_len <= por_len + 8'h01;
  end
  AST_FAULT_WAKE: assert property (DEEP_SLEEP_O && WAKE_SRC_I.fault |=> POR_ACTIVE_O)
    else $error("fault in deep sleep gave no wake reset");
  AST_MASTER_CLEAR_PIN_WAKE: assert property (DEEP_SLEEP_O && WAKE_SRC_I.master_clear_pin |=> POR_ACTIVE_O && !DEEP_SLEEP_O)
    else $error("reset pin in deep sleep gave no wake reset");
  AST_STAY_DEEP: assert property (DEEP_SLEEP_O && !(|WAKE_SRC_I)
    && !(SUPPLY_I.deep_sleep_brownout_flag_en && SUPPLY_I.deep_sleep_brownout_flag_trip) |=> DEEP_SLEEP_O)
    else $error("deep sleep left with no wake request");
  AST_CMD_TAKEN: assert property (SLEEP_CMD_I && !DEEP_SLEEP_O && !POR_ACTIVE_O
    |=> SLEEP_O || DEEP_SLEEP_O)
    else $error("sleep command entered no sleep mode");
  AST_SLEEP_PULSE: assert property (SLEEP_O |-> !DEEP_SLEEP_O ##1 !SLEEP_O)
    else $error("ordinary sleep pulse wrong");
  AST_ULP_RUN: assert property (ULP_UNIT_RUN_O |-> DEEP_SLEEP_O)
    else $error("wake unit running outside deep sleep");
  AST_POR_LEN: assert property (POR_ACTIVE_O |-> por_len < POR_CYCLES)
    else $error("wake reset too long");
  AST_POR_EXIT: assert property ($rose(POR_ACTIVE_O) |-> ##[1:40] DEEP_SLEEP_EXIT_O)
    else $error("wake reset without exit pulse");
endmodule

bind dswc_top dswc_props #(.POR_CYCLES(POR_CYCLES)) i_props (
  .MCLK_I(MCLK_I), .RST_I(RST_I), .SLEEP_CMD_I(SLEEP_CMD_I), .WAKE_SRC_I(WAKE_SRC_I),
  .SUPPLY_I(SUPPLY_I), .DEEP_SLEEP_O(DEEP_SLEEP_O), .SLEEP_O(SLEEP_O),
  .POR_ACTIVE_O(POR_ACTIVE_O), .DEEP_SLEEP_EXIT_O(DEEP_SLEEP_EXIT_O),
  .ULP_UNIT_RUN_O(ULP_UNIT_RUN_O));

// file: bench/testbench.sv
// testbench: register access, sleep entry and a table of wake cases
// assumes the design package and dswc_cfg.svh on the include path
`timescale 1ns/1ps
module testbench;
  import dswc_pkg::*;
  `include "dswc_cfg.svh"
  localparam logic [15:0] a_wl = {2'b00, `DSWC_IDX_WAKE_LOW, 2'b00};
  localparam logic [15:0] a_wh = {2'b00, `DSWC_IDX_WAKE_HIGH, 2'b00};
  localparam logic [15:0] a_cl = {2'b00, `DSWC_IDX_CTRL_LOW, 2'b00};
  localparam logic [15:0] a_ch = {2'b00, `DSWC_IDX_CTRL_HIGH, 2'b00};
  localparam logic [15:0] a_s0 = {2'b00, `DSWC_IDX_SCRATCH0, 2'b00};
  localparam logic [1:0]  rok  = `DSWC_RESP_OKAY;
  localparam logic [1:0]  rse  = `DSWC_RESP_SLVERR;
  logic clk = 0, rst = 1, awv = 0, wv = 0, arv = 0, slp = 0;
  logic [15:0] awa = 16'h0000, ara = 16'h0000;
  logic [31:0] wd = 32'h0;
  logic [7:0]  dir = 8'h0f, lat = 8'ha5;
  dswc_wake_t   wk = '0;
  dswc_supply_t sup = '0;
  wire awr, wrd, bv, arr, rv, ds, sl, ex, ulp, por;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [7:0] poe, pout;
  int fails = 0, cmp_count = 0, n_sl = 0;
  // wdt with calendar and ulp held off, fault, master_clear_pin, calendar, ulp, pin, por event
  logic [7:0] ctl [7] = '{8'h83, 8'h80, 8'h80, 8'h80, 8'h82, 8'h80, 8'h80};
  logic [6:0] pre [7] = '{7'h06, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
  logic [6:0] src [7] = '{7'h08, 7'h40, 7'h10, 7'h04, 7'h02, 7'h01, 7'h20};
  logic [7:0] wl  [7] = '{8'h10, 8'h80, 8'h04, 8'h08, 8'h20, 8'h00, 8'h01};
  logic [7:0] wh  [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [7:0] cl  [7] = '{8'h07, 8'h01, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01};

  dswc_top #(.INSTR_CLKS(1), .POR_CYCLES(4)) i_dut (
    .MCLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'h1), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(1'b1),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(1'b1),
    .SLEEP_CMD_I(slp), .WAKE_SRC_I(wk), .SUPPLY_I(sup), .PIN_DIRECTION_I(dir),
    .OUTPUT_LATCH_I(lat), .PIN_OUT_O(pout), .PIN_OE_N_O(poe), .DEEP_SLEEP_O(ds),
    .SLEEP_O(sl), .POR_ACTIVE_O(por), .DEEP_SLEEP_EXIT_O(ex), .ULP_UNIT_RUN_O(ulp));

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  always #2.5 clk = ~clk;
  always @(negedge clk) if (sl) n_sl++;

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // handshake signals are read at the falling edge, so the rising edge sees them settled
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    do begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrd;
      tb = bv;
      r = br;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end while (!tb);
    chk("bresp", r, er);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    do begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv;
      d = rdat;
      r = rr;
      @(posedge clk);
      if (ta) arv <= 0;
    end while (!tr);
    chk("rdata", d, {24'h0, e});
    chk("rresp", r, er);
  endtask

  // both readies fall together, so both items go at one edge; lag sets the command slot
  task automatic ds_try(input int lag, input logic [7:0] d);
    @(posedge clk);
    awa <= a_ch;
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    do @(negedge clk); while (!(awr && wrd));
    @(posedge clk);
    awv <= 0;
    wv <= 0;
    repeat (lag) @(posedge clk);
    slp <= 1;
    @(posedge clk);
    slp <= 0;
  endtask

  task automatic give_verdict;
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    rd(a_wl, 8'h01, rok);
    rd(a_wh, 8'h00, rok);
    rd(a_cl, 8'h00, rok);
    rd(16'h0100, 8'h00, rse);
    wr(16'h0100, 8'h11, rse);
    wr(a_s0, 8'h5a, rok);
    wr(a_ch, 8'h03, rok);
    rd(a_ch, 8'h03, rok);
    ds_try(3, 8'h80);
    repeat (3) @(negedge clk);
    chk("deep", ds, 0);
    chk("sleeps", n_sl, 1);
    rd(a_ch, 8'h00, rok);
    wr(a_cl, 8'h04, rok);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      dir <= 8'h0f;
      lat <= 8'ha5;
      ds_try(1, ctl[i]);
      repeat (2) @(negedge clk);
      chk("deep", ds, 1);
      chk("ulp run", ulp, ctl[i][1]);
      @(posedge clk);
      wk <= pre[i];
      sup.deep_sleep_brownout_flag_arm <= cl[i][1];
      dir <= 8'hf0;
      lat <= 8'h3c;
      repeat (3) @(negedge clk);
      chk("held", ds, 1);
      @(posedge clk);
      wk <= src[i];
      @(posedge clk);
      wk <= src[i] | 7'h02;
      @(posedge clk);
      wk <= '0;
      sup <= '0;
      @(negedge clk);
      chk("por", por, 1);
      do @(negedge clk); while (!ex);
      chk("por end", por, 0);
      rd(a_wl, wl[i], rok);
      rd(a_wh, wh[i], rok);
      rd(a_cl, cl[i], rok);
      rd(a_s0, 8'h5a, rok);
      chk("pins", poe, cl[i][0] ? 8'h0f : 8'hf0);
      chk("pin data", pout, cl[i][0] ? 8'ha5 : 8'h3c);
      wr(a_cl, 8'h00, rok);
      repeat (2) @(negedge clk);
      chk("released", poe, 8'hf0);
      chk("released data", pout, 8'h3c);
    end
    give_verdict;
  end

  // a few hundred cycles expected; this cuts a hang well after that
  initial begin
    #20000;
    fails++;
    give_verdict;
  end
endmodule
